// ### eeprom_pkg.sv
package eeprom_pkg;

  // ****************************************
  // Geometry and address word layout
  // ****************************************
  localparam int          WORD_BITS     = 8;
  localparam int          ADDR_BITS     = 10;
  localparam int          DEPTH         = 1024;
  localparam logic [3:0]  TYPE_PREFIX   = 4'hA;
  localparam int          BIT_CNT_ACK   = 8;
  localparam logic [3:0]  BIT_CNT_INIT  = 4'h0;
  localparam logic [9:0]  ADDR_RST      = 10'h000;
  localparam logic [7:0]  DATA_RST      = 8'h00;

  // ****************************************
  // Self-timed program time
  // ****************************************
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          PROG_TIME_MS  = 5;
  localparam int          PROG_CYCLES   = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_DEV   = 3'b001,
    ST_WADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_IGN   = 3'b101
  } phase_t;

endpackage

// ### eeprom_mem.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Array storage with registered read data
// ****************************************
module eeprom_mem
(
  // Clock
  input  wire logic       clk,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [9:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Read port
  input  wire logic [9:0] rd_addr,
  output logic      [7:0] rd_data
);

  logic [7:0] mem [0:eeprom_pkg::DEPTH-1];

  // Storage has no reset: contents are nonvolatile.
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// ### eeprom_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Two-flop level synchroniser
// ****************************************
module eeprom_sync
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level
  input  wire logic d,
  output logic      q
);

  logic meta_ff;

  // Meta stage is read only by the second stage.
  // Both bus lines idle high, so the stages reset high; a low reset value would fake an edge.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= 1'b1;
      q       <= 1'b1;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// ### eeprom_target.sv
`timescale 1ns/1ps
`default_nettype none

module eeprom_target
#(
  parameter bit PART_8K     = 1'b0,
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
)
(
  // System clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Serial clock, the link clock
  input  wire logic scl_clk,
  // Open-drain data line
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  // Hard-wired select pins
  input  wire logic chip_select_pin_high,
  input  wire logic chip_select_pin_mid,
  input  wire logic chip_select_pin_low,
  // Status
  output logic      busy,
  output logic      standby
);

  // ****************************************
  // Pin synchronisers into the system domain
  // ****************************************
  logic scl_s;
  logic sda_s;
  logic scl_d_ff;
  logic sda_d_ff;

  eeprom_sync u_sync_scl (.clk(clk_sys), .rst(sys_rst), .d(scl_clk), .q(scl_s));
  eeprom_sync u_sync_sda (.clk(clk_sys), .rst(sys_rst), .d(sda_in),  .q(sda_s));

  // Edge history of the synchronised pins.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Data edges while the clock stays high frame the transfers.
  assign scl_rise  = scl_s & ~scl_d_ff;
  assign scl_fall  = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // ****************************************
  // Address match decode
  // ****************************************
  function automatic logic addr_match(input logic [7:0] w, input logic h, input logic m);
    logic ok;
    ok = (w[7:4] == eeprom_pkg::TYPE_PREFIX);
    if (PART_8K)
    begin
      ok = ok & (w[3] == h);
    end
    else
    begin
      ok = ok & (w[3] == h) & (w[2] == m);
    end
    return ok;
  endfunction

  // ****************************************
  // Protocol state
  // ****************************************
  eeprom_pkg::phase_t phase_ff;
  eeprom_pkg::phase_t nxt_phase;
  logic [3:0]  bit_cnt_ff;
  logic [7:0]  shift_ff;
  logic        ack_slot_ff;
  logic        ack_due_ff;
  logic        drive_ff;
  logic [9:0]  addr_ff;
  logic [7:0]  tx_ff;
  logic        wrote_ff;
  logic        prog_ff;
  logic [31:0] prog_cnt_ff;
  logic        mem_we;
  logic [7:0]  mem_rd;
  logic [9:0]  page_hi;
  logic [7:0]  rx_word;
  logic        byte_done;

  // Upper address bits carried in the device word, masked to the array size.
  assign page_hi   = PART_8K ? {rx_word[2:1], 8'h00} : {1'b0, rx_word[1], 8'h00};
  assign rx_word   = {shift_ff[6:0], sda_s};
  assign byte_done = scl_rise & (bit_cnt_ff == 4'd7) & ~ack_slot_ff;

  eeprom_mem u_mem
  (
    .clk     (clk_sys),
    .wr_en   (mem_we),
    .wr_addr (addr_ff),
    .wr_data (rx_word),
    .rd_addr (addr_ff),
    .rd_data (mem_rd)
  );

  // Writes land directly at the current address during the data byte.
  assign mem_we = byte_done & (phase_ff == eeprom_pkg::ST_WDATA);

  // Phase sequencing on whole words.
  always_comb
  begin
    nxt_phase = phase_ff;
    if (start_det)
    begin
      nxt_phase = prog_ff ? eeprom_pkg::ST_IGN : eeprom_pkg::ST_DEV;
    end
    else if (stop_det)
    begin
      nxt_phase = eeprom_pkg::ST_IDLE;
    end
    else if (byte_done)
    begin
      unique case (phase_ff)
        eeprom_pkg::ST_DEV:
        begin
          if (!addr_match(rx_word, chip_select_pin_high, chip_select_pin_mid))
            nxt_phase = eeprom_pkg::ST_IGN;
          else if (rx_word[0])
            nxt_phase = eeprom_pkg::ST_RDATA;
          else
            nxt_phase = eeprom_pkg::ST_WADDR;
        end
        eeprom_pkg::ST_WADDR: nxt_phase = eeprom_pkg::ST_WDATA;
        eeprom_pkg::ST_WDATA: nxt_phase = eeprom_pkg::ST_WDATA;
        eeprom_pkg::ST_RDATA, eeprom_pkg::ST_IDLE, eeprom_pkg::ST_IGN: nxt_phase = phase_ff;
        default:              nxt_phase = eeprom_pkg::ST_IGN;
      endcase
    end
    // A read ends when the controller leaves its acknowledge high.
    else if (phase_ff == eeprom_pkg::ST_RDATA && ack_slot_ff && !ack_due_ff && scl_rise && sda_s)
    begin
      nxt_phase = eeprom_pkg::ST_IGN;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      phase_ff <= eeprom_pkg::ST_IDLE;
    else
      phase_ff <= nxt_phase;
  end

  // Bit counter and shift register; the ninth clock is the acknowledge slot.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bit_cnt_ff  <= eeprom_pkg::BIT_CNT_INIT;
      ack_slot_ff <= 1'b0;
      ack_due_ff  <= 1'b0;
      shift_ff    <= eeprom_pkg::DATA_RST;
    end
    else if (start_det || stop_det)
    begin
      bit_cnt_ff  <= eeprom_pkg::BIT_CNT_INIT;
      ack_slot_ff <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (ack_slot_ff)
      begin
        ack_slot_ff <= 1'b0;
        bit_cnt_ff  <= eeprom_pkg::BIT_CNT_INIT;
      end
      else
      begin
        shift_ff <= rx_word;
        if (bit_cnt_ff == 4'd7)
        begin
          ack_slot_ff <= 1'b1;
          ack_due_ff  <= (phase_ff inside {eeprom_pkg::ST_WADDR, eeprom_pkg::ST_WDATA}) ||
                         (phase_ff == eeprom_pkg::ST_DEV &&
                          addr_match(rx_word, chip_select_pin_high, chip_select_pin_mid));
        end
        else
          bit_cnt_ff <= bit_cnt_ff + 4'd1;
      end
    end
  end

  // Address counter: page bits from a write device word, low byte from the word address.
  // Every byte sent steps it, acknowledged or not, so it always points past the last access.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      addr_ff <= eeprom_pkg::ADDR_RST;
    else if (byte_done && phase_ff == eeprom_pkg::ST_WADDR)
      addr_ff <= {addr_ff[9:8], rx_word};
    else if (byte_done && phase_ff == eeprom_pkg::ST_DEV && !rx_word[0]
             && addr_match(rx_word, chip_select_pin_high, chip_select_pin_mid))
      addr_ff <= page_hi | {2'b00, addr_ff[7:0]};
    else if (mem_we)
      addr_ff <= {addr_ff[9:4], addr_ff[3:0] + 4'd1};
    else if (phase_ff == eeprom_pkg::ST_RDATA && scl_rise && ack_slot_ff && !ack_due_ff)
      addr_ff <= PART_8K ? addr_ff + 10'd1 : {1'b0, addr_ff[8:0] + 9'd1};
  end

  // Outgoing byte is captured at the start of each read byte.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      tx_ff <= eeprom_pkg::DATA_RST;
    else if (phase_ff == eeprom_pkg::ST_RDATA && scl_fall && !ack_slot_ff)
      tx_ff <= (bit_cnt_ff == 4'd0) ? {mem_rd[6:0], 1'b0} : {tx_ff[6:0], 1'b0};
  end

  // Read data are one cycle behind the address, so the first bit comes from memory.
  logic tx_bit;
  assign tx_bit = (bit_cnt_ff == 4'd0) ? mem_rd[7] : tx_ff[7];

  // Pull low after a falling edge only; released elsewhere.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      drive_ff <= 1'b0;
    else if (start_det || stop_det)
      drive_ff <= 1'b0;
    else if (scl_fall && ack_slot_ff)
      drive_ff <= ack_due_ff & ~prog_ff;
    else if (scl_fall)
      drive_ff <= (phase_ff == eeprom_pkg::ST_RDATA) & ~tx_bit;
  end

  // Open drain: the pin only ever pulls low, enabled by the drive flag.
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_ff;

  // ****************************************
  // Self-timed programming
  // ****************************************
  // A write is pending once any data byte was taken; the stop launches programming.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrote_ff    <= 1'b0;
      prog_ff     <= 1'b0;
      prog_cnt_ff <= 32'd0;
    end
    else if (prog_ff)
    begin
      if (prog_cnt_ff == 32'(PROG_CYCLES - 1))
        prog_ff <= 1'b0;
      prog_cnt_ff <= prog_cnt_ff + 32'd1;
    end
    else if (stop_det && wrote_ff)
    begin
      wrote_ff    <= 1'b0;
      prog_ff     <= 1'b1;
      prog_cnt_ff <= 32'd0;
    end
    else if (start_det)
      wrote_ff <= 1'b0;
    else if (mem_we)
      wrote_ff <= 1'b1;
  end

  assign busy    = prog_ff;
  assign standby = (phase_ff == eeprom_pkg::ST_IDLE) & ~prog_ff;

  // ****************************************
  // Checks
  // ****************************************
  property p_prog_len;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(prog_ff) |-> prog_ff[*8];
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("programming ended early");

  property p_stop_prog;
    @(posedge clk_sys) disable iff (sys_rst)
    (stop_det && wrote_ff && !prog_ff) |=> prog_ff;
  endproperty
  a_stop_prog: assert property (p_stop_prog) else $error("stop did not start programming");

  property p_no_ack_busy;
    @(posedge clk_sys) disable iff (sys_rst)
    prog_ff |-> !drive_ff;
  endproperty
  a_no_ack_busy: assert property (p_no_ack_busy) else $error("drove line while busy");

  property p_start_phase;
    @(posedge clk_sys) disable iff (sys_rst)
    (start_det && !prog_ff) |=> phase_ff == eeprom_pkg::ST_DEV;
  endproperty
  a_start_phase: assert property (p_start_phase) else $error("start not seen");

  property p_stop_idle;
    @(posedge clk_sys) disable iff (sys_rst)
    stop_det |=> phase_ff == eeprom_pkg::ST_IDLE && !drive_ff;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

  property p_page_wrap;
    @(posedge clk_sys) disable iff (sys_rst)
    mem_we |=> addr_ff[9:4] == $past(addr_ff[9:4]) && addr_ff[3:0] == $past(addr_ff[3:0]) + 4'd1;
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("write address step wrong");

  property p_ign_release;
    @(posedge clk_sys) disable iff (sys_rst)
    (phase_ff == eeprom_pkg::ST_IGN && $past(phase_ff) == eeprom_pkg::ST_IGN) |-> !drive_ff;
  endproperty
  a_ign_release: assert property (p_ign_release) else $error("drove line while ignoring");

  property p_drive_on_fall;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(drive_ff) |-> $past(scl_fall);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("drive changed off clock fall");

  c_write:  cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(prog_ff));
  c_read:   cover property (@(posedge clk_sys) disable iff (sys_rst) phase_ff == eeprom_pkg::ST_RDATA);
  c_nomatch: cover property (@(posedge clk_sys) disable iff (sys_rst)
                             $past(phase_ff) == eeprom_pkg::ST_DEV && phase_ff == eeprom_pkg::ST_IGN);

endmodule
`default_nettype wire

// ### i2c_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Two-wire bus controller model
// ****************************************
module i2c_ctrl_model
(
  // Link reference clock
  input  wire logic tick,
  // Bus
  input  wire logic sda_line,
  output logic      scl_clk,
  output logic      pull_sda
);
  event       got;
  logic [7:0] seen;

  // The serial clock idles high and stands still between frames.
  initial
  begin
    scl_clk  = 1'b1;
    pull_sda = 1'b0;
  end

  // Every change is launched just after a link tick, never on it.
  task automatic step();
    @(posedge tick);
    #2;
  endtask

  // Data falls while the clock is high; the same task gives a repeated start.
  task automatic send_start();
    pull_sda = 1'b0;
    step();
    scl_clk = 1'b1;
    step();
    pull_sda = 1'b1;
    step();
    scl_clk = 1'b0;
    step();
  endtask

  // Data rises while the clock is high, then the bus is left free.
  task automatic send_stop();
    pull_sda = 1'b1;
    step();
    scl_clk = 1'b1;
    step();
    pull_sda = 1'b0;
    step();
  endtask

  // Data is set in the low phase and sampled at the end of the high phase.
  task automatic bit_cycle(input logic out_b, output logic in_b);
    pull_sda = ~out_b;
    step();
    scl_clk = 1'b1;
    step();
    step();
    in_b = sda_line;
    scl_clk = 1'b0;
    step();
  endtask

  // One byte most significant bit first, then the ninth clock.
  task automatic xfer(input logic [7:0] tx, input logic ack_out, input logic is_rd);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cycle(is_rd | tx[i], b);
      seen[i] = b;
    end
    bit_cycle(~is_rd | ack_out, b);
    if (!is_rd)
      seen = {7'h00, b};
    -> got;
  endtask
endmodule

`default_nettype wire

// ### serial_eeprom_two_wire_target_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Self-checking bench
// ****************************************
module serial_eeprom_two_wire_target_bench;
  // A short programming time keeps the run brief but outlasts one poll.
  localparam int PROG = 1000;
  logic       clk_sys;
  logic       sys_rst;
  logic       tick;
  logic       scl_clk;
  logic       pull_sda;
  logic       sda_line;
  logic       sda_out;
  logic       sda_oe_n;
  logic       pin_high;
  logic       pin_mid;
  logic       pin_low;
  logic       busy;
  logic       standby;
  logic       dummy;
  logic [7:0] mem [512];
  logic [8:0] ptr;
  logic [7:0] exp_q [$];
  int         num_errors;
  int         samples_checked;

  // Pulled-up line: whichever party pulls low wins.
  assign sda_line = ~pull_sda & (sda_oe_n | sda_out);

  // System clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Link clock, with a phase unrelated to the system clock.
  initial
  begin
    tick = 1'b0;
    #7;
    forever #80 tick = ~tick;
  end

  eeprom_target
  #(
    .PART_8K     (1'b0),
    .PROG_CYCLES (PROG)
  )
  u_dut
  (
    .clk_sys              (clk_sys),
    .sys_rst              (sys_rst),
    .scl_clk              (scl_clk),
    .sda_in               (sda_line),
    .sda_out              (sda_out),
    .sda_oe_n             (sda_oe_n),
    .chip_select_pin_high (pin_high),
    .chip_select_pin_mid  (pin_mid),
    .chip_select_pin_low  (pin_low),
    .busy                 (busy),
    .standby              (standby)
  );

  i2c_ctrl_model u_ctrl
  (
    .tick     (tick),
    .sda_line (sda_line),
    .scl_clk  (scl_clk),
    .pull_sda (pull_sda)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want || $isunknown(seen))
    begin
      num_errors++;
      $display("BAD at %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [7:0] devw(input logic pg, input logic rd);
    return {eeprom_pkg::TYPE_PREFIX, pin_high, pin_mid, pg, rd};
  endfunction

  // Sends a byte and notes the acknowledge level it should draw.
  task automatic wr(input logic [7:0] v, input logic [7:0] e);
    exp_q.push_back(e);
    u_ctrl.xfer(v, 1'b1, 1'b0);
  endtask

  // Busy must hold off a poll, then end in time and leave standby.
  task automatic settle();
    realtime t0;
    t0 = $realtime;
    repeat (6) @(posedge clk_sys);
    #2;
    chk({7'h00, busy}, 8'h01);
    u_ctrl.send_start();
    wr(devw(1'b0, 1'b1), 8'h01);
    u_ctrl.send_stop();
    for (int w = 0; w < 2 * PROG && busy !== 1'b0; w++)
      @(posedge clk_sys);
    @(posedge clk_sys);
    #2;
    chk({6'h00, busy, standby}, 8'h01);
    chk({7'h00, $realtime - t0 <= (PROG + 8) * 25.0}, 8'h01);
  endtask

  // Writes n random bytes; the model wraps inside the page.
  task automatic write_seq(input logic [8:0] a, input int n);
    logic [7:0] v;
    u_ctrl.send_start();
    wr(devw(a[8], 1'b0), 8'h00);
    wr(a[7:0], 8'h00);
    for (int k = 0; k < n; k++)
    begin
      v = 8'($urandom);
      mem[{a[8:4], a[3:0] + 4'(k)}] = v;
      wr(v, 8'h00);
    end
    u_ctrl.send_stop();
    settle();
  endtask

  // Dummy write, repeated start, then n bytes with the last one not acknowledged.
  task automatic read_seq(input logic [8:0] a, input int n);
    u_ctrl.send_start();
    wr(devw(a[8], 1'b0), 8'h00);
    wr(a[7:0], 8'h00);
    u_ctrl.send_start();
    wr(devw(a[8], 1'b1), 8'h00);
    for (int k = 0; k < n; k++)
    begin
      exp_q.push_back(mem[9'(a + k)]);
      u_ctrl.xfer(8'hFF, k == n - 1, 1'b1);
    end
    u_ctrl.send_stop();
    // The counter steps past the last byte sent, the refused one included.
    ptr = 9'(a + n);
  endtask

  // Each reported result retires the oldest expectation.
  initial
  begin
    forever
    begin
      @(u_ctrl.got);
      chk(u_ctrl.seen, exp_q.pop_front());
    end
  end

  // Cuts a hang short well after the expected run length.
  initial
  begin
    #1000000;
    num_errors++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(32'h89AE));
    num_errors = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    {pin_high, pin_mid, pin_low} = 3'($urandom);
    repeat (16) @(posedge clk_sys);
    #2;
    sys_rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    #2;
    chk({6'h00, busy, standby}, 8'h01);
    chk({7'h00, sda_oe_n}, 8'h01);
    write_seq(9'h000, 2);
    write_seq(9'h1FF, 1);
    write_seq(9'h10C, 20);
    read_seq(9'h100, 16);
    read_seq(9'h1FF, 2);
    // Current read at the counter left by the last read.
    u_ctrl.send_start();
    wr(devw(ptr[8], 1'b1), 8'h00);
    exp_q.push_back(mem[ptr]);
    u_ctrl.xfer(8'hFF, 1'b1, 1'b1);
    u_ctrl.send_stop();
    // Wrong select bit, then wrong type prefix: both stay silent.
    u_ctrl.send_start();
    wr({eeprom_pkg::TYPE_PREFIX, ~pin_high, pin_mid, 2'b00}, 8'h01);
    wr(8'h00, 8'h01);
    u_ctrl.send_start();
    wr({~eeprom_pkg::TYPE_PREFIX, pin_high, pin_mid, 2'b00}, 8'h01);
    u_ctrl.send_stop();
    // Straps tied low as in the five-lead option: select bits go out as zeros.
    {pin_high, pin_mid, pin_low} = 3'h0;
    // Bus recovery sequence, then a normal access must work.
    u_ctrl.send_start();
    repeat (9) u_ctrl.bit_cycle(1'b1, dummy);
    u_ctrl.send_start();
    u_ctrl.send_stop();
    read_seq(9'h10C, 1);
    wrap_up();
  end
endmodule

`default_nettype wire
